// ### hdl/bus_size_pkg.sv
// Purpose: Shared types and constants for the dynamic bus sizing engine
// Assumes: 16-bit external data bus, 8- or 16-bit ports
// Notes: Operands are right-justified in bus_req_t and bus_rsp_t, most significant byte first
package bus_size_pkg;

	// =========================================================
	// Widths
	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	localparam int BUS_W = 16;
	localparam int FIFO_DEPTH = 16;

	// =========================================================
	// Operand sizes and byte counts
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} op_size_t;
	localparam logic [2:0] BYTES_BYTE = 3'h1;
	localparam logic [2:0] BYTES_WORD = 3'h2;
	localparam logic [2:0] BYTES_LONG = 3'h4;
	localparam logic [2:0] STEP_PORT8 = 3'h1;
	localparam logic [2:0] STEP_PORT16 = 3'h2;

	// =========================================================
	// Size acknowledge codes {hi, lo}
	localparam logic [1:0] ACK_WAIT = 2'h3;
	localparam logic [1:0] ACK_PORT8 = 2'h2;
	localparam logic [1:0] ACK_PORT16 = 2'h1;
	localparam logic [1:0] ACK_RSVD = 2'h0;

	// =========================================================
	// Request carried through the FIFO
	typedef struct packed {
		logic write;
		op_size_t size;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_t;
	localparam int REQ_W = $bits(bus_req_t);

	// Completion returned to the master
	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic error;
	} bus_rsp_t;

	// External bus cycle signals
	typedef struct packed {
		logic active;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [BUS_W-1:0] wdata;
	} ext_cyc_t;

endpackage

// ### hdl/bus_sizer.sv
// Purpose: Splits master operands into 8- or 16-bit external bus cycles
// Assumes: Size acknowledge pins are asynchronous and are synchronised here
// Notes: Requests are queued in a 16-entry FIFO ahead of the sequencer
`timescale 1ns/1ps

// =============================================================
// Request FIFO
module req_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} fifo_st_t;
	fifo_st_t s_q, s_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	assign in_ready = s_q.count != DEPTH[AW:0];
	assign out_valid = s_q.count != '0;
	assign out_data = mem[s_q.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		s_d = s_q;
		if (push)
			s_d.wr = s_q.wr + 1'b1;
		if (pop)
			s_d.rd = s_q.rd + 1'b1;
		if (push && !pop)
			s_d.count = s_q.count + 1'b1;
		else if (pop && !push)
			s_d.count = s_q.count - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem[s_q.wr] <= in_data;
	end
endmodule

// =============================================================
// Sizing sequencer
module bus_sizer
	import bus_size_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Master request
	input wire logic req_valid,
	output logic req_ready,
	input wire bus_req_t req,
	// Master completion
	output logic rsp_valid,
	output bus_rsp_t rsp,
	// External bus
	output ext_cyc_t ext,
	output logic [BUS_W-1:0] data_oe,
	input wire logic [BUS_W-1:0] data_in,
	input wire logic size_ack_hi,
	input wire logic size_ack_lo
);
	typedef enum logic [1:0] {ST_IDLE, ST_CYCLE, ST_SETTLE} state_t;

	typedef struct packed {
		state_t state;
		bus_req_t cur;
		logic [2:0] left;
		logic [DATA_W-1:0] rbuf;
		logic [1:0] ack_s1;
		logic [1:0] ack_s2;
		logic [1:0] ack_s3;
		ext_cyc_t ext;
		logic [BUS_W-1:0] oe;
		logic rsp_valid;
		bus_rsp_t rsp;
	} st_t;
	st_t s_q, s_d;

	logic f_valid, f_ready;
	bus_req_t f_data;
	logic [1:0] ack;
	logic ack_stable;
	logic ack_idle;
	logic [2:0] step;
	logic [DATA_W-1:0] shifted;

	req_fifo #(
		.WIDTH(REQ_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rstn(rstn),
		.in_valid(req_valid),
		.in_ready(req_ready),
		.in_data(req),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);

	assign f_ready = s_q.state == ST_IDLE && ack_idle;
	assign ack = s_q.ack_s3;
	assign ack_stable = s_q.ack_s2 == s_q.ack_s3;
	// Last acknowledge must have drained before a new operand opens
	assign ack_idle = ack_stable && ack == ACK_WAIT;
	assign ext = s_q.ext;
	assign data_oe = s_q.oe;
	assign rsp_valid = s_q.rsp_valid;
	assign rsp = s_q.rsp;

	always_comb
	begin
		s_d = s_q;
		s_d.ack_s1 = {size_ack_hi, size_ack_lo};
		s_d.ack_s2 = s_q.ack_s1;
		s_d.ack_s3 = s_q.ack_s2;
		s_d.rsp_valid = 1'b0;
		step = STEP_PORT16;
		shifted = s_q.cur.wdata;
		case (s_q.state)
			ST_IDLE:
			begin
				if (f_valid && ack_idle)
				begin
					s_d.cur = f_data;
					s_d.rbuf = '0;
					case (f_data.size)
						SZ_BYTE: s_d.left = BYTES_BYTE;
						SZ_WORD: s_d.left = BYTES_WORD;
						default: s_d.left = BYTES_LONG;
					endcase
					// Left-justify so the most significant operand byte leads
					case (f_data.size)
						SZ_BYTE: s_d.cur.wdata = {f_data.wdata[7:0], 24'h000000};
						SZ_WORD: s_d.cur.wdata = {f_data.wdata[15:0], 16'h0000};
						default: s_d.cur.wdata = f_data.wdata;
					endcase
					s_d.ext.active = 1'b1;
					s_d.ext.write = f_data.write;
					s_d.ext.addr = f_data.addr;
					s_d.state = ST_CYCLE;
				end
			end
			ST_CYCLE:
			begin
				// Always present the widest lanes, full 16 bits
				s_d.ext.wdata = s_q.cur.wdata[DATA_W-1 -: BUS_W];
				s_d.oe = s_q.cur.write ? {BUS_W{1'b1}} : '0;
				if (ack_stable && ack != ACK_WAIT)
				begin
					if (ack == ACK_RSVD)
					begin
						s_d.ext = '0;
						s_d.oe = '0;
						s_d.rsp_valid = 1'b1;
						s_d.rsp.error = 1'b1;
						s_d.rsp.rdata = '0;
						s_d.state = ST_IDLE;
					end
					else
					begin
						// Port width is decoded from each acknowledge
						step = (ack == ACK_PORT8) ? STEP_PORT8 : STEP_PORT16;
						if (step > s_q.left)
							step = s_q.left;
						if (step == STEP_PORT16)
							s_d.rbuf = {s_q.rbuf[DATA_W-BUS_W-1:0], data_in};
						else
							s_d.rbuf = {s_q.rbuf[DATA_W-9:0], data_in[15:8]};
						shifted = (step == STEP_PORT16) ? {s_q.cur.wdata[DATA_W-BUS_W-1:0], 16'h0000}
							: {s_q.cur.wdata[DATA_W-9:0], 8'h00};
						s_d.cur.wdata = shifted;
						s_d.left = s_q.left - step;
						s_d.ext.active = 1'b0;
						s_d.oe = '0;
						s_d.ext.addr = s_q.ext.addr + ADDR_W'(step);
						if (s_q.left == step)
						begin
							s_d.rsp_valid = 1'b1;
							s_d.rsp.error = 1'b0;
							s_d.rsp.rdata = s_q.cur.write ? '0 : s_d.rbuf;
							s_d.ext = '0;
							s_d.state = ST_IDLE;
						end
						else
							s_d.state = ST_SETTLE;
					end
				end
			end
			ST_SETTLE:
			begin
				// Wait for the ack lines to return to idle
				if (ack_stable && ack == ACK_WAIT)
				begin
					s_d.ext.active = 1'b1;
					s_d.state = ST_CYCLE;
				end
			end
			default: s_d.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			s_q <= '0;
			s_q.state <= ST_IDLE;
			s_q.ack_s1 <= ACK_WAIT;
			s_q.ack_s2 <= ACK_WAIT;
			s_q.ack_s3 <= ACK_WAIT;
		end
		else
			s_q <= s_d;
	end
endmodule

// ### verification/bus_sizer_chk.sv
// Purpose: Port assertions for bus_sizer
// Assumes: Ack pair {hi,lo} passes a 3-flop sync
// Notes: Bound to every bus_sizer
`timescale 1ns/1ps
// ===================================
// Checker
module bus_sizer_chk import bus_size_pkg::*; (
	// Watched ports
	input wire logic clk,
	input wire logic rstn,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire bus_rsp_t rsp,
	input wire ext_cyc_t ext,
	input wire logic [BUS_W-1:0] data_oe,
	input wire logic size_ack_hi,
	input wire logic size_ack_lo
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	wire logic [1:0] k = {size_ack_hi, size_ack_lo};
	a_wait_holds: assert property ((ext.active && k == 2'h3) [*4] |=> ext.active)
		else $error("wait ended cycle");
	a_ack_done: assert property ((ext.active && k == 2'h1) [*4] |-> ##[0:3] !ext.active)
		else $error("ack not taken");
	a_rsvd_error: assert property ((ext.active && k == 2'h0) [*4] |-> ##[0:4] (rsp_valid && rsp.error))
		else $error("no error");
	a_read_lanes: assert property (ext.active && !ext.write |-> data_oe == 16'h0)
		else $error("read drives");
	a_write_lanes: assert property (ext.active && $past(ext.active) && ext.write |-> data_oe == 16'hffff)
		else $error("write lanes");
	a_addr_hold: assert property (ext.active && $past(ext.active) |-> $stable(ext.addr) && $stable(ext.write))
		else $error("addr moved");
	a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
		else $error("long pulse");
	a_rsp_hold: assert property (!rsp_valid |-> $stable(rsp))
		else $error("rsp moved");
	c_error: cover property (rsp_valid && rsp.error);
	c_port8: cover property (ext.active && k == 2'h2);
	c_full: cover property (!req_ready);
endmodule
bind bus_sizer bus_sizer_chk chk (.*);

// ### verification/port_model.sv
// Purpose: External 8- or 16-bit port
// Assumes: Byte at address a reads a+11h
// Notes: Lanes not driven show inverted data
`timescale 1ns/1ps
// ===================================
// Port model
module port_model import bus_size_pkg::*; (
	// Bus side
	input wire logic clk,
	input wire ext_cyc_t ext,
	output logic [BUS_W-1:0] data_in,
	output logic size_ack_hi,
	output logic size_ack_lo,
	// Behaviour
	input wire logic p8,
	input wire logic rsv,
	input wire logic [3:0] wt
);
	logic [3:0] c = 4'h0;
	logic [7:0] wm [16];
	logic on;
	function automatic logic [7:0] m(input logic [ADDR_W-1:0] a);
		return a[7:0] + 8'h11;
	endfunction
	assign on = ext.active && c >= wt;
	assign {size_ack_hi, size_ack_lo} = !on ? 2'h3 : rsv ? 2'h0 : p8 ? 2'h2 : 2'h1;
	assign data_in = on ? {m(ext.addr), p8 ? ~m(ext.addr) : m(ext.addr + 24'h1)}
		: ~{m(ext.addr), m(ext.addr + 24'h1)};
	always @(posedge clk)
	begin
		c <= ext.active ? c + {3'h0, c != 4'hf} : 4'h0;
		if (on && ext.write)
		begin
			wm[ext.addr[3:0]] <= ext.wdata[15:8];
			if (!p8)
				wm[ext.addr[3:0] + 4'h1] <= ext.wdata[7:0];
		end
	end
endmodule

// ### verification/tb.sv
// Purpose: Self-checking bench for bus_sizer
// Assumes: Port model width switched between operations within a test
// Notes: One task per scenario
`timescale 1ns/1ps
// ===================================
// Bench
module tb import bus_size_pkg::*;;
	logic clk, rstn, req_valid, p8, rsv, req_ready, rsp_valid, size_ack_hi, size_ack_lo;
	logic [3:0] wt;
	bus_req_t req;
	bus_rsp_t rsp;
	ext_cyc_t ext;
	logic [BUS_W-1:0] data_oe, data_in;
	int error_cnt, num_checks, n;
	int n_cyc, c0, cyc;
	logic act_q;
	bus_sizer dut (
		.clk(clk),
		.rstn(rstn),
		.req_valid(req_valid),
		.req_ready(req_ready),
		.req(req),
		.rsp_valid(rsp_valid),
		.rsp(rsp),
		.ext(ext),
		.data_oe(data_oe),
		.data_in(data_in),
		.size_ack_hi(size_ack_hi),
		.size_ack_lo(size_ack_lo)
	);
	port_model pm (
		.clk(clk),
		.ext(ext),
		.data_in(data_in),
		.size_ack_hi(size_ack_hi),
		.size_ack_lo(size_ack_lo),
		.p8(p8),
		.rsv(rsv),
		.wt(wt)
	);
	// Count opened external bus cycles
	always @(posedge clk)
	begin
		act_q <= ext.active;
		if (ext.active && !act_q)
			n_cyc <= n_cyc + 1;
	end
	initial
	begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	task stop_test;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected at %0t: %h vs %h", $time, g, e);
		end
	endtask
	task wrsp;
		int i;
		for (i = 0; i < 400; i++)
		begin
			@(negedge clk);
			if (rsp_valid === 1'b1)
				break;
		end
		chk(i < 400, 1);
	endtask
	task op(input logic w, input op_size_t s, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		c0 = n_cyc;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{w, s, a, d};
		@(negedge clk);
		while (req_ready !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		req_valid <= 1'b0;
		wrsp;
		cyc = n_cyc - c0;
	endtask
	task t_reads;
		op(1'b0, SZ_LONG, 24'h10, 32'h0);
		chk(rsp.rdata, 32'h21222324);
		chk(cyc, 2);
		chk(rsp.error, 1'b0);
		op(1'b0, SZ_BYTE, 24'h33, 32'h0);
		chk(rsp.rdata, 32'h44);
		chk(cyc, 1);
		p8 = 1;
		wt = 4'h5;
		op(1'b0, SZ_LONG, 24'h40, 32'h0);
		chk(rsp.rdata, 32'h51525354);
		chk(cyc, 4);
		op(1'b0, SZ_WORD, 24'h7, 32'h0);
		chk(rsp.rdata, 32'h1819);
		chk(cyc, 2);
		$display("reads done");
	endtask
	task t_writes;
		op(1'b1, SZ_WORD, 24'h4, 32'hbeef);
		chk({pm.wm[4], pm.wm[5]}, 16'hbeef);
		chk(cyc, 2);
		p8 = 0;
		op(1'b1, SZ_WORD, 24'h8, 32'hcafe);
		chk({pm.wm[8], pm.wm[9]}, 16'hcafe);
		chk(cyc, 1);
		rsv = 1;
		op(1'b0, SZ_LONG, 24'h20, 32'h0);
		chk(rsp.error, 1'b1);
		chk(cyc, 1);
		rsv = 0;
		$display("writes done");
	endtask
	task t_fifo;
		wt = 4'hf;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{1'b1, SZ_BYTE, 24'h0, 32'h5a};
		// Sixteen queued plus one taken by the sequencer
		for (n = 0; n <= FIFO_DEPTH; n++)
		begin
			@(negedge clk);
			chk(req_ready, 1'b1);
			@(posedge clk);
		end
		req_valid <= 1'b0;
		@(negedge clk);
		chk(req_ready, 1'b0);
		repeat (n) wrsp;
		chk(pm.wm[0], 8'h5a);
		$display("fifo done");
	endtask
	initial
	begin
		rstn = 1'b0;
		req_valid = 1'b0;
		p8 = 1'b0;
		rsv = 1'b0;
		wt = 4'h0;
		req = '0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		t_reads;
		t_writes;
		t_fifo;
		stop_test;
	end
	initial
	begin
		#100000;
		error_cnt++;
		stop_test;
	end
endmodule
